// >>> icrtc_pkg.sv
/*
 * Shared definitions for the isolated calendar clock block: timing constants,
 * the unlock key, BCD field limits, write-select codes, modes and the time carrier,
 * followed by the BCD field counter that the top module instantiates.
 * Assumes a single 20 MHz core clock and a synchronous, active-high power-on reset.
 */
package icrtc_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned SLOW_HZ        = 32_768;
  localparam int unsigned MS_PER_S       = 1_000;
  localparam int unsigned SYNC_SLOW_TICKS = 2;
  localparam int unsigned PHASE_W        = 25;
  localparam int unsigned MSACC_W        = 16;

  localparam logic [15:0] UNLOCK_KEY_LO = 16'hF1E0;
  localparam logic [15:0] UNLOCK_KEY_HI = 16'h95A4;

  localparam logic [11:0] MS_MIN    = 12'h000;
  localparam logic [11:0] MS_MAX    = 12'h999;
  localparam int unsigned NFIELDS   = 7;
  // Field order: second, minute, hour, weekday, date, month, year.
  localparam logic [7:0] FIELD_MIN [NFIELDS] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] FIELD_MAX [NFIELDS] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
  localparam int unsigned F_SEC   = 0;
  localparam int unsigned F_MIN   = 1;
  localparam int unsigned F_HOUR  = 2;
  localparam int unsigned F_WDAY  = 3;
  localparam int unsigned F_DATE  = 4;
  localparam int unsigned F_MONTH = 5;
  localparam int unsigned F_YEAR  = 6;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam logic [7:0] DAYS_28   = 8'h28;
  localparam logic [7:0] DAYS_29   = 8'h29;
  localparam logic [7:0] DAYS_30   = 8'h30;
  localparam logic [7:0] DAYS_31   = 8'h31;

  typedef enum logic [4:0] {
    SEL_MS, SEL_SEC, SEL_MIN, SEL_HOUR, SEL_WDAY, SEL_DATE, SEL_MONTH, SEL_YEAR,
    SEL_ALM_SEC, SEL_ALM_MIN, SEL_ALM_HOUR, SEL_ALM_DAY, SEL_ALM_MODE, SEL_PER_MODE,
    SEL_CAL, SEL_SCRATCH0, SEL_SCRATCH1
  } icrtc_sel_t;

  typedef enum logic [2:0] {ALM_OFF, ALM_SEC, ALM_MIN, ALM_HOUR, ALM_DAY} icrtc_alm_t;
  typedef enum logic [2:0] {PER_OFF, PER_MS, PER_SEC, PER_MIN, PER_HOUR, PER_DAY} icrtc_per_t;

  typedef struct packed {
    logic [11:0] ms;
    logic [7:0]  sec;
    logic [7:0]  min;
    logic [7:0]  hour;
    logic [7:0]  wday;
    logic [7:0]  date;
    logic [7:0]  month;
    logic [7:0]  year;
  } icrtc_time_t;

  typedef struct packed {
    icrtc_sel_t  sel;
    logic [15:0] data;
  } icrtc_wr_t;
endpackage

`timescale 1ns/1ns
module icrtc_bcd_field #(
  parameter  int DIGITS = 2,
  localparam int W      = 4 * DIGITS
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         inc,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic [W-1:0] min_val,
  input  wire logic [W-1:0] max_val,
  output logic      [W-1:0] value_r,
  output logic              wrap
);
  logic [W-1:0] value_nxt;

  always_comb begin
    logic       c;
    logic [3:0] d;
    c         = 1'b1;
    d         = 4'h0;
    value_nxt = value_r;
    wrap      = inc && (value_r >= max_val);
    if (load) begin
      value_nxt = load_val;
    end else if (wrap) begin
      value_nxt = min_val;
    end else if (inc) begin
      for (int i = 0; i < DIGITS; i++) begin
        d = value_r[4*i +: 4];
        if (c) begin
          if (d == 4'h9) begin
            d = 4'h0;
          end else begin
            d = d + 4'h1;
            c = 1'b0;
          end
        end
        value_nxt[4*i +: 4] = d;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      value_r <= '0;
    end else begin
      value_r <= value_nxt;
    end
  end
endmodule

// >>> icrtc_top.sv
/*
 * Isolated calendar clock: BCD time of day and calendar, alarm and periodic
 * interrupt, wake pin, guarded and delayed register writes, scratch words.
 * Assumes core_clk at 20 MHz with all inputs synchronous to it, and rst being
 * the block's own power-on reset; no device reset reaches this logic.
 */
// Overview of operation
// - Alarm, periodic or wake input wakes processor.
// - Write needs oscillator, isolation release, correct key.
// - Missing condition keeps block isolated, writes rejected.
// - Writes land after two slow clock cycles.
// - Only own power-on reset clears state.
// - Count milliseconds to years, leap years, 2099.
// - Values held in BCD, 24-hour hours.
// - Alarm matches second, minute, hour or day.
// - Periodic interrupt per ms, s, min, h, day.
// - All interrupt sources share one output.
// - Slow clock rate trimmed by calibration value.
// - Wake pin is input or output by choice.
// - Scratch words survive device resets.
`timescale 1ns/1ns
module icrtc_top
  import icrtc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        osc_en,
  input  wire logic        isolation_release_control,
  input  wire logic [15:0] unlock_key_low_half,
  input  wire logic [15:0] unlock_key_high_half,
  input  wire logic        wr_req,
  input  wire icrtc_wr_t   wr_cmd,
  input  wire logic        alarm_clr,
  input  wire logic        periodic_clr,
  input  wire logic        wake_dir_out,
  input  wire logic        wake_pin_i,
  output logic             wake_pin_o,
  output logic             wake_pin_oe,
  output icrtc_time_t      time_o,
  output logic             wr_busy,
  output logic             wr_rejected,
  output logic             alarm_flag,
  output logic             periodic_flag,
  output logic             irq,
  output logic             cpu_wake,
  output logic [15:0]      scratch0,
  output logic [15:0]      scratch1
);
  localparam logic [PHASE_W-1:0] PHASE_MOD  = PHASE_W'(CLK_HZ);
  localparam logic [PHASE_W-1:0] PHASE_STEP = PHASE_W'(SLOW_HZ);
  localparam logic [MSACC_W-1:0] MS_STEP    = MSACC_W'(MS_PER_S);
  localparam logic [MSACC_W-1:0] MS_MOD     = MSACC_W'(SLOW_HZ);
  localparam logic [1:0]         SYNC_CNT   = 2'(SYNC_SLOW_TICKS);

  function automatic logic leap_year(input logic [7:0] y);
    // Years 2000..2099: every multiple of four is a leap year, 2000 included.
    if (y[4]) begin
      leap_year = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      leap_year = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic leap);
    case (m)
      MONTH_FEB: month_days = leap ? DAYS_29 : DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = DAYS_30;
      default: month_days = DAYS_31;
    endcase
  endfunction

  // Slow-rate and millisecond tick generation.
  logic [PHASE_W-1:0] phase_r, phase_nxt;
  logic [MSACC_W-1:0] msacc_r, msacc_nxt;
  logic signed [15:0] cal_r, cal_nxt;
  logic               slow_tick_r, slow_tick_nxt;
  logic               ms_tick_r, ms_tick_nxt;
  logic [PHASE_W:0]   phase_sum;

  always_comb begin
    phase_sum     = {1'b0, phase_r} + {1'b0, PHASE_STEP} + {{(PHASE_W-15){cal_r[15]}}, cal_r};
    phase_nxt     = phase_r;
    slow_tick_nxt = 1'b0;
    msacc_nxt     = msacc_r;
    ms_tick_nxt   = 1'b0;
    if (osc_en) begin
      // Calibration trims the effective slow rate in steps of one hertz.
      if (phase_sum[PHASE_W-1:0] >= PHASE_MOD) begin
        phase_nxt     = phase_sum[PHASE_W-1:0] - PHASE_MOD;
        slow_tick_nxt = 1'b1;
      end else begin
        phase_nxt = phase_sum[PHASE_W-1:0];
      end
    end
    if (slow_tick_r) begin
      if (msacc_r + MS_STEP >= MS_MOD) begin
        msacc_nxt   = msacc_r + MS_STEP - MS_MOD;
        ms_tick_nxt = 1'b1;
      end else begin
        msacc_nxt = msacc_r + MS_STEP;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_r     <= '0;
      msacc_r     <= '0;
      slow_tick_r <= 1'b0;
      ms_tick_r   <= 1'b0;
    end else begin
      phase_r     <= phase_nxt;
      msacc_r     <= msacc_nxt;
      slow_tick_r <= slow_tick_nxt;
      ms_tick_r   <= ms_tick_nxt;
    end
  end

  // Guarded write path: accepted only when unlocked, applied two slow ticks later.
  icrtc_wr_t  pend_r, pend_nxt;
  logic       pend_vld_r, pend_vld_nxt;
  logic [1:0] pend_cnt_r, pend_cnt_nxt;
  logic       busy_r, busy_nxt;
  logic       rej_r, rej_nxt;
  logic       apply;
  logic       unlocked;

  // Ignored writes only pulse wr_rejected and leave all other state untouched, so glitches cannot corrupt it.
  assign unlocked = osc_en && isolation_release_control &&
                    (unlock_key_low_half == UNLOCK_KEY_LO) &&
                    (unlock_key_high_half == UNLOCK_KEY_HI);
  assign apply    = pend_vld_r && slow_tick_r && (pend_cnt_r == SYNC_CNT - 2'h1);

  always_comb begin
    pend_nxt     = pend_r;
    pend_vld_nxt = pend_vld_r;
    pend_cnt_nxt = pend_cnt_r;
    rej_nxt      = 1'b0;
    if (apply) begin
      pend_vld_nxt = 1'b0;
      pend_cnt_nxt = '0;
    end else if (pend_vld_r && slow_tick_r) begin
      pend_cnt_nxt = pend_cnt_r + 2'h1;
    end
    // A second write while one is in flight is refused; the core clock must be fast
    // enough to see each slow tick as a separate enable.
    if (wr_req) begin
      if (unlocked && !pend_vld_r) begin
        pend_nxt     = wr_cmd;
        pend_vld_nxt = 1'b1;
        pend_cnt_nxt = '0;
      end else begin
        rej_nxt = 1'b1;
      end
    end
    busy_nxt = pend_vld_nxt;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_r     <= '{sel: SEL_MS, data: 16'h0000};
      pend_vld_r <= 1'b0;
      pend_cnt_r <= '0;
      busy_r     <= 1'b0;
      rej_r      <= 1'b0;
    end else begin
      pend_r     <= pend_nxt;
      pend_vld_r <= pend_vld_nxt;
      pend_cnt_r <= pend_cnt_nxt;
      busy_r     <= busy_nxt;
      rej_r      <= rej_nxt;
    end
  end

  // Calendar counters.
  logic [11:0] ms_val;
  logic        ms_wrap;
  logic [7:0]  fval [NFIELDS];
  logic [7:0]  fmax [NFIELDS];
  logic        finc [NFIELDS];
  logic        fwrap [NFIELDS];
  logic        ms_load;

  assign ms_load = apply && (pend_r.sel == SEL_MS);

  icrtc_bcd_field #(.DIGITS(3)) u_ms (
    .core_clk (core_clk),
    .rst      (rst),
    .inc      (ms_tick_r),
    .load     (ms_load),
    .load_val (pend_r.data[11:0]),
    .min_val  (MS_MIN),
    .max_val  (MS_MAX),
    .value_r  (ms_val),
    .wrap     (ms_wrap)
  );

  always_comb begin
    // Weekday and date both step at midnight; weekday never carries.
    finc[F_SEC]   = ms_wrap;
    finc[F_MIN]   = fwrap[F_SEC];
    finc[F_HOUR]  = fwrap[F_MIN];
    finc[F_WDAY]  = fwrap[F_HOUR];
    finc[F_DATE]  = fwrap[F_HOUR];
    finc[F_MONTH] = fwrap[F_DATE];
    finc[F_YEAR]  = fwrap[F_MONTH];
    for (int i = 0; i < NFIELDS; i++) begin
      fmax[i] = FIELD_MAX[i];
    end
    fmax[F_DATE] = month_days(fval[F_MONTH], leap_year(fval[F_YEAR]));
  end

  genvar g;
  generate
    for (g = 0; g < NFIELDS; g++) begin : g_field
      icrtc_bcd_field #(.DIGITS(2)) u_fld (
        .core_clk (core_clk),
        .rst      (rst),
        .inc      (finc[g]),
        .load     (apply && (pend_r.sel == icrtc_sel_t'(g + 1))),
        .load_val (pend_r.data[7:0]),
        .min_val  (FIELD_MIN[g]),
        .max_val  (fmax[g]),
        .value_r  (fval[g]),
        .wrap     (fwrap[g])
      );
    end
  endgenerate

  // Alarm, periodic, scratch and wake state.
  logic [7:0]  alm_sec_r, alm_min_r, alm_hour_r, alm_day_r;
  logic [7:0]  alm_sec_nxt, alm_min_nxt, alm_hour_nxt, alm_day_nxt;
  icrtc_alm_t  alm_mode_r, alm_mode_nxt;
  icrtc_per_t  per_mode_r, per_mode_nxt;
  logic [15:0] scr0_r, scr0_nxt, scr1_r, scr1_nxt;
  logic        sec_step_r, alm_hit, per_hit;
  logic        alm_f_r, alm_f_nxt, per_f_r, per_f_nxt;
  logic        irq_r, irq_nxt, wake_r, wake_nxt, wo_r, wo_nxt, woe_r, woe_nxt;

  always_comb begin
    alm_sec_nxt  = alm_sec_r;
    alm_min_nxt  = alm_min_r;
    alm_hour_nxt = alm_hour_r;
    alm_day_nxt  = alm_day_r;
    alm_mode_nxt = alm_mode_r;
    per_mode_nxt = per_mode_r;
    cal_nxt      = cal_r;
    scr0_nxt     = scr0_r;
    scr1_nxt     = scr1_r;
    if (apply) begin
      case (pend_r.sel)
        SEL_ALM_SEC:  alm_sec_nxt  = pend_r.data[7:0];
        SEL_ALM_MIN:  alm_min_nxt  = pend_r.data[7:0];
        SEL_ALM_HOUR: alm_hour_nxt = pend_r.data[7:0];
        SEL_ALM_DAY:  alm_day_nxt  = pend_r.data[7:0];
        SEL_ALM_MODE: alm_mode_nxt = icrtc_alm_t'(pend_r.data[2:0]);
        SEL_PER_MODE: per_mode_nxt = icrtc_per_t'(pend_r.data[2:0]);
        SEL_CAL:      cal_nxt      = pend_r.data;
        SEL_SCRATCH0: scr0_nxt     = pend_r.data;
        SEL_SCRATCH1: scr1_nxt     = pend_r.data;
        default:      cal_nxt      = cal_r;
      endcase
    end
    // Compare one cycle after the second steps, once all carries have settled.
    alm_hit = 1'b0;
    if (sec_step_r) begin
      case (alm_mode_r)
        ALM_SEC:  alm_hit = fval[F_SEC] == alm_sec_r;
        ALM_MIN:  alm_hit = fval[F_SEC] == alm_sec_r && fval[F_MIN] == alm_min_r;
        ALM_HOUR: alm_hit = fval[F_SEC] == alm_sec_r && fval[F_MIN] == alm_min_r &&
                            fval[F_HOUR] == alm_hour_r;
        ALM_DAY:  alm_hit = fval[F_SEC] == alm_sec_r && fval[F_MIN] == alm_min_r &&
                            fval[F_HOUR] == alm_hour_r && fval[F_DATE] == alm_day_r;
        default:  alm_hit = 1'b0;
      endcase
    end
    case (per_mode_r)
      PER_MS:   per_hit = ms_tick_r;
      PER_SEC:  per_hit = ms_wrap;
      PER_MIN:  per_hit = fwrap[F_SEC];
      PER_HOUR: per_hit = fwrap[F_MIN];
      PER_DAY:  per_hit = fwrap[F_HOUR];
      default:  per_hit = 1'b0;
    endcase
    // An event in the same cycle as its clear keeps the flag set.
    alm_f_nxt = alm_hit || (alm_f_r && !alarm_clr);
    per_f_nxt = per_hit || (per_f_r && !periodic_clr);
    irq_nxt   = alm_f_nxt || per_f_nxt;
    wake_nxt  = irq_nxt || (!wake_dir_out && wake_pin_i);
    wo_nxt    = wake_dir_out && irq_nxt;
    woe_nxt   = wake_dir_out;
  end

  // Only the block's own power-on reset clears this state.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alm_sec_r  <= '0;
      alm_min_r  <= '0;
      alm_hour_r <= '0;
      alm_day_r  <= '0;
      alm_mode_r <= ALM_OFF;
      per_mode_r <= PER_OFF;
      cal_r      <= '0;
      scr0_r     <= '0;
      scr1_r     <= '0;
      sec_step_r <= 1'b0;
      alm_f_r    <= 1'b0;
      per_f_r    <= 1'b0;
      irq_r      <= 1'b0;
      wake_r     <= 1'b0;
      wo_r       <= 1'b0;
      woe_r      <= 1'b0;
    end else begin
      alm_sec_r  <= alm_sec_nxt;
      alm_min_r  <= alm_min_nxt;
      alm_hour_r <= alm_hour_nxt;
      alm_day_r  <= alm_day_nxt;
      alm_mode_r <= alm_mode_nxt;
      per_mode_r <= per_mode_nxt;
      cal_r      <= cal_nxt;
      scr0_r     <= scr0_nxt;
      scr1_r     <= scr1_nxt;
      sec_step_r <= ms_wrap;
      alm_f_r    <= alm_f_nxt;
      per_f_r    <= per_f_nxt;
      irq_r      <= irq_nxt;
      wake_r     <= wake_nxt;
      wo_r       <= wo_nxt;
      woe_r      <= woe_nxt;
    end
  end

  assign time_o        = '{ms: ms_val, sec: fval[F_SEC], min: fval[F_MIN],
                           hour: fval[F_HOUR], wday: fval[F_WDAY], date: fval[F_DATE],
                           month: fval[F_MONTH], year: fval[F_YEAR]};
  assign wr_busy       = busy_r;
  assign wr_rejected   = rej_r;
  assign alarm_flag    = alm_f_r;
  assign periodic_flag = per_f_r;
  assign irq           = irq_r;
  assign cpu_wake      = wake_r;
  assign wake_pin_o    = wo_r;
  assign wake_pin_oe   = woe_r;
  assign scratch0      = scr0_r;
  assign scratch1      = scr1_r;
endmodule

// >>> icrtc_top_sva.sv
/*
 * Port-level checker for icrtc_top: write guard, write delay, flags, wake pin, BCD counts.
 * Assumes icrtc_pkg is compiled first and that the bind below reaches every icrtc_top.
 */
`timescale 1ns/1ns
module icrtc_top_sva
  import icrtc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        osc_en,
  input wire logic        isolation_release_control,
  input wire logic [15:0] unlock_key_low_half,
  input wire logic [15:0] unlock_key_high_half,
  input wire logic        wr_req,
  input wire logic        wr_busy,
  input wire logic        wr_rejected,
  input wire logic        alarm_clr,
  input wire logic        alarm_flag,
  input wire logic        periodic_flag,
  input wire logic        irq,
  input wire logic        cpu_wake,
  input wire logic        wake_dir_out,
  input wire logic        wake_pin_i,
  input wire logic        wake_pin_oe,
  input wire icrtc_time_t time_o
);
  logic        wr_ok;
  logic [10:0] busy_len_r;

  assign wr_ok = osc_en && isolation_release_control && !wr_busy
                 && unlock_key_low_half == UNLOCK_KEY_LO && unlock_key_high_half == UNLOCK_KEY_HI;

  // Counts busy cycles so the two-slow-tick delay can be bounded on both sides.
  always_ff @(posedge core_clk) begin
    if (rst || !wr_busy) begin
      busy_len_r <= 11'h000;
    end else begin
      busy_len_r <= busy_len_r + 11'h001;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_accept_busy: assert property (wr_req && wr_ok |=> wr_busy && !wr_rejected)
    else $error("accepted write did not raise busy");
  a_refuse_pulse: assert property (wr_req && !wr_ok |=> wr_rejected)
    else $error("refused write gave no reject pulse");
  a_reject_cause: assert property (wr_rejected |-> $past(wr_req) && !$past(wr_ok))
    else $error("reject pulse without a refused request");
  a_write_delay: assert property ($fell(wr_busy) |-> busy_len_r >= 11'h258 && busy_len_r <= 11'h4CE)
    else $error("write landed outside two slow ticks");
  a_busy_bounded: assert property (wr_busy |-> busy_len_r < 11'h4D8)
    else $error("write stayed pending too long");
  a_irq_or: assert property (irq == (alarm_flag || periodic_flag))
    else $error("irq is not the OR of the flags");
  // The wake register loads from the same next value as irq, so it rises with irq, not after it.
  a_wake_cause: assert property (!$past(rst) |->
      cpu_wake == (irq || $past(!wake_dir_out && wake_pin_i)))
    else $error("cpu_wake does not follow its causes");
  a_pin_dir: assert property (!$past(rst) |-> wake_pin_oe == $past(wake_dir_out))
    else $error("wake pin enable does not follow direction");
  a_alarm_sticky: assert property (alarm_flag && !alarm_clr |=> alarm_flag)
    else $error("alarm flag dropped without clear");
  a_bcd_fields: assert property (time_o.sec[3:0] <= 4'h9 && time_o.sec <= 8'h59 && time_o.hour <= 8'h23 && time_o.hour[3:0] <= 4'h9)
    else $error("time field is not legal BCD");
  a_sec_on_ms: assert property ($changed(time_o.sec) && !$past(wr_busy) |-> time_o.ms == 12'h000)
    else $error("second stepped without millisecond wrap");
  a_osc_frozen: assert property (!osc_en [*3] |=> $stable(time_o))
    else $error("time moved with oscillator off");

  c_alarm: cover property ($rose(alarm_flag));
  c_periodic: cover property ($rose(periodic_flag));
  c_write_done: cover property ($fell(wr_busy));
  c_reject: cover property (wr_rejected);
endmodule

bind icrtc_top icrtc_top_sva icrtc_top_sva_i (.core_clk, .rst, .osc_en, .isolation_release_control,
  .unlock_key_low_half, .unlock_key_high_half, .wr_req, .wr_busy, .wr_rejected, .alarm_clr,
  .alarm_flag, .periodic_flag, .irq, .cpu_wake, .wake_dir_out, .wake_pin_i, .wake_pin_oe, .time_o);

// >>> icrtc_top_test.sv
/*
 * Self-checking bench for icrtc_top: table of writes, calendar rollovers, flags, wake pin, refusals.
 * Assumes icrtc_pkg and the bound checker are compiled before this file.
 */
`timescale 1ns/1ns
module icrtc_top_test
  import icrtc_pkg::*;
;
  typedef struct packed {
    icrtc_sel_t  s;
    logic [15:0] d;
    logic        c;
  } icrtc_row_t;

  // Sets 2099-12-31 23:59:59 with a day alarm at 01 00:00:00, ms last so it wraps soon.
  localparam icrtc_row_t ROWS [16] = '{
    '{SEL_SCRATCH0, 16'hA5C3, 1'b1}, '{SEL_SCRATCH1, 16'h5A3C, 1'b1}, '{SEL_YEAR, 16'h0099, 1'b1},
    '{SEL_MONTH, 16'h0012, 1'b1}, '{SEL_DATE, 16'h0031, 1'b1}, '{SEL_WDAY, 16'h0007, 1'b1},
    '{SEL_HOUR, 16'h0023, 1'b1}, '{SEL_MIN, 16'h0059, 1'b1}, '{SEL_SEC, 16'h0059, 1'b1},
    '{SEL_ALM_SEC, 16'h0000, 1'b0}, '{SEL_ALM_MIN, 16'h0000, 1'b0}, '{SEL_ALM_HOUR, 16'h0000, 1'b0},
    '{SEL_ALM_DAY, 16'h0001, 1'b0}, '{SEL_ALM_MODE, {13'h0000, ALM_DAY}, 1'b0},
    '{SEL_PER_MODE, {13'h0000, PER_DAY}, 1'b0}, '{SEL_MS, 16'h0999, 1'b1}};

  logic        core_clk, rst, osc_en, isolation_release_control, wr_req, alarm_clr;
  logic        periodic_clr, wake_dir_out, ext_wake, wake_pin_i, wake_pin_o, wake_pin_oe;
  logic        wr_busy, wr_rejected, alarm_flag, periodic_flag, irq, cpu_wake, last_rej;
  logic [15:0] unlock_key_low_half, unlock_key_high_half, scratch0, scratch1;
  icrtc_wr_t   wr_cmd;
  icrtc_time_t time_o;
  int          errors, n_checks, cyc, gap;

  // The pin level seen by the block: its own drive when enabled, else the outside source.
  assign wake_pin_i = wake_pin_oe ? wake_pin_o : ext_wake;

  icrtc_top icrtc_top_i (.core_clk, .rst, .osc_en, .isolation_release_control,
    .unlock_key_low_half, .unlock_key_high_half, .wr_req, .wr_cmd, .alarm_clr, .periodic_clr,
    .wake_dir_out, .wake_pin_i, .wake_pin_o, .wake_pin_oe, .time_o, .wr_busy, .wr_rejected,
    .alarm_flag, .periodic_flag, .irq, .cpu_wake, .scratch0, .scratch1);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic finish_test;
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 99000) begin
      errors++;
      finish_test;
    end
  end

  task automatic chk(string name, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", name, e, g);
    end
  endtask

  task automatic chk_time(icrtc_time_t e);
    n_checks++;
    if (time_o !== e) begin
      errors++;
      $display("BAD time_o exp %h got %h", e, time_o);
    end
  endtask

  function automatic logic [15:0] status();
    status = {11'h000, wr_busy, alarm_flag, periodic_flag, irq, cpu_wake};
  endfunction

  function automatic logic [15:0] field(icrtc_sel_t s);
    if (s == SEL_MS) begin
      field = {4'h0, time_o.ms};
    end else if (s <= SEL_YEAR) begin
      field = {8'h00, time_o[(56 - 8 * int'(s)) +: 8]};
    end else begin
      field = (s == SEL_SCRATCH0) ? scratch0 : scratch1;
    end
  endfunction

  // Ends on a falling edge, so callers sample settled outputs right after it returns.
  task automatic done;
    int n;
    @(negedge core_clk);
    last_rej = wr_rejected;
    for (n = 0; n < 1400 && wr_busy !== 1'b0; n++) @(negedge core_clk);
    chk("wr_busy", 16'h0000, {15'h0000, wr_busy});
  endtask

  task automatic wr(icrtc_sel_t s, logic [15:0] d);
    @(posedge core_clk);
    wr_cmd <= '{s, d};
    wr_req <= 1'b1;
    @(posedge core_clk);
    wr_req <= 1'b0;
    done;
  endtask

  task automatic roll(icrtc_time_t e);
    int n;
    for (n = 0; n < 25000 && time_o.sec === 8'h59; n++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    chk_time(e);
  endtask

  // Falling edges between two millisecond steps, so the trimmed rate can be measured.
  task automatic ms_gap(output int g);
    int          n;
    logic [11:0] m;
    m = time_o.ms;
    for (n = 0; n < 25000 && time_o.ms === m; n++) @(negedge core_clk);
    m = time_o.ms;
    for (g = 0; g < 25000 && time_o.ms === m; g++) @(negedge core_clk);
  endtask

  initial begin
    rst = 1'b1;
    osc_en = 1'b1;
    isolation_release_control = 1'b1;
    unlock_key_low_half = UNLOCK_KEY_LO;
    unlock_key_high_half = UNLOCK_KEY_HI;
    wr_req = 1'b0;
    wr_cmd = '0;
    alarm_clr = 1'b0;
    periodic_clr = 1'b0;
    wake_dir_out = 1'b0;
    ext_wake = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    chk_time('0);
    chk("status", 16'h0000, status());
    foreach (ROWS[i]) begin
      wr(ROWS[i].s, ROWS[i].d);
      chk("wr_rejected", 16'h0000, {15'h0000, last_rej});
      if (ROWS[i].c) chk(ROWS[i].s.name(), ROWS[i].d, field(ROWS[i].s));
    end
    roll('{12'h000, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
    chk("status", 16'h000F, status());
    @(posedge core_clk);
    alarm_clr <= 1'b1;
    periodic_clr <= 1'b1;
    @(posedge core_clk);
    alarm_clr <= 1'b0;
    periodic_clr <= 1'b0;
    ext_wake <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk("status", 16'h0001, status());
    @(posedge core_clk);
    ext_wake <= 1'b0;
    @(posedge core_clk);
    wake_dir_out <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("wake_out", 16'h0002, {14'h0000, wake_pin_oe, cpu_wake});
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      osc_en <= (k != 0);
      isolation_release_control <= (k != 1);
      unlock_key_high_half <= (k == 2) ? 16'h95A5 : UNLOCK_KEY_HI;
      wr(SEL_SCRATCH0, 16'h1234);
      chk("wr_rejected", 16'h0001, {15'h0000, last_rej});
      chk("scratch0", 16'hA5C3, scratch0);
    end
    @(posedge core_clk);
    unlock_key_high_half <= UNLOCK_KEY_HI;
    wr_cmd <= '{SEL_SCRATCH1, 16'hBEEF};
    wr_req <= 1'b1;
    @(posedge core_clk);
    wr_cmd <= '{SEL_SCRATCH0, 16'h1234};
    @(posedge core_clk);
    wr_req <= 1'b0;
    done;
    chk("wr_rejected", 16'h0001, {15'h0000, last_rej});
    chk("scratch1", 16'hBEEF, scratch1);
    chk("scratch0", 16'hA5C3, scratch0);
    wr(SEL_PER_MODE, {13'h0000, PER_MS});
    wr(SEL_ALM_MODE, {13'h0000, ALM_HOUR});
    wr(SEL_DATE, 16'h0028);
    wr(SEL_MONTH, 16'h0002);
    wr(SEL_YEAR, 16'h0024);
    wr(SEL_HOUR, 16'h0023);
    wr(SEL_MIN, 16'h0059);
    wr(SEL_SEC, 16'h0059);
    wr(SEL_MS, 16'h0999);
    roll('{12'h000, 8'h00, 8'h00, 8'h00, 8'h02, 8'h29, 8'h02, 8'h24});
    chk("status", 16'h000F, status());
    chk("wake_pin_o", 16'h0001, {15'h0000, wake_pin_o});
    // Nearly doubling the slow rate must halve the millisecond step from about 20000 cycles.
    wr(SEL_CAL, 16'h7FFF);
    ms_gap(gap);
    chk("ms_gap", 16'h0001, {15'h0000, gap > 9000 && gap < 12000});
    finish_test;
  end
endmodule
